/* File: inc/qslr_pkg.sv */
`default_nettype none
package qslr_pkg;
    // register selection within one channel (word index)
    localparam logic [1:0] REG_RX_CS   = 2'h0;
    localparam logic [1:0] REG_RX_BUF  = 2'h1;
    localparam logic [1:0] REG_TX_CS   = 2'h2;
    localparam logic [1:0] REG_TX_BUF  = 2'h3;
    // field positions
    localparam int         DONE_BIT    = 7;
    localparam int         IE_BIT      = 6;
    localparam int         ADV_BIT     = 0;
    localparam int         BRK_BIT     = 0;
    localparam int         ERR_BIT     = 15;
    localparam int         OVR_BIT     = 14;
    localparam int         FRM_BIT     = 13;
    localparam int         PAR_BIT     = 12;
    // values after reset; all but the vector also after bus initialise
    localparam logic       RST_RX_DONE = 1'b0;
    localparam logic       RST_TX_RDY  = 1'b1;
    localparam logic       RST_IE      = 1'b0;
    localparam logic [7:0] RST_VECTOR  = 8'h00;
    // vector spacing between functions
    localparam logic [7:0] VEC_STEP    = 8'h04;
    localparam int         NUM_CH      = 4;

    // one register access from the processor side
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [1:0]  chan;
        logic [1:0]  sel;
        logic [15:0] wdata;
    } qslr_bus_t;

    // one character handed up by a receiver
    typedef struct packed {
        logic       done;
        logic [7:0] data;
        logic       frm_err;
        logic       par_err;
    } qslr_rx_t;
endpackage : qslr_pkg
`default_nettype wire

/* File: logic/qslr_core.sv */
`timescale 1ns/1ps
`default_nettype none
module qslr_core #(
    parameter logic [7:0] BASE_VECTOR = 8'h00
) (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic                   bus_init,
    input  wire qslr_pkg::qslr_bus_t    bus_req,
    output logic [15:0]                 bus_rdata,
    output logic                        bus_rvalid,
    output logic                        irq_req,
    input  wire logic                   ack_in,
    output logic                        ack_out,
    output logic [7:0]                  vec_data,
    output logic                        vec_valid,
    input  wire qslr_pkg::qslr_rx_t [3:0] rx_evt,
    input  wire logic [3:0]             cfg_seven_bit,
    input  wire logic [3:0]             cfg_parity_en,
    output logic [3:0]                  rdr_advance,
    output logic [3:0]                  tx_load,
    output logic [7:0]                  tx_data,
    input  wire logic [3:0]             tx_taken,
    output logic [3:0]                  tx_break
);
    // flag storage, one bit per channel
    logic [3:0] rx_done_q;
    logic [3:0] rx_done_d;
    logic [3:0] rx_ie_q;
    logic [3:0] rx_ie_d;
    logic [3:0] tx_rdy_q;
    logic [3:0] tx_rdy_d;
    logic [3:0] tx_ie_q;
    logic [3:0] tx_ie_d;
    logic [3:0] tx_brk_q;
    logic [3:0] tx_brk_d;
    logic [3:0] ovr_q;
    logic [3:0] frm_q;
    logic [3:0] par_q;
    logic [7:0] rx_data_q [4];
    logic [7:0] tx_data_q;
    logic [3:0] tx_load_q;
    logic [3:0] adv_q;
    logic [15:0] rdata_q;
    logic        rvalid_q;
    logic [7:0]  vec_q;
    logic        vec_valid_q;
    logic        ack_in_q;

    // decoded strobes per channel
    logic [3:0] chan_hit;
    logic [3:0] wr_rcs;
    logic [3:0] wr_tcs;
    logic [3:0] wr_tbuf;
    logic [3:0] rd_rx_data_buffer;
    logic [3:0] clr_done;
    logic [3:0] rx_set;
    logic [7:0] req_vec;
    logic       any_req;
    logic [2:0] win_idx;
    logic       grant_edge;
    logic [15:0] rd_mux;

    // fixed ranking: lowest index wins, receivers occupy 0..3
    function automatic logic [2:0] prio_pick(input logic [7:0] r);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (r[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : prio_pick

    // channel decode of the bus access
    assign chan_hit = 4'h1 << bus_req.chan;
    assign wr_rcs   = (bus_req.wr && bus_req.sel == qslr_pkg::REG_RX_CS)
                      ? chan_hit : 4'h0;
    assign wr_tcs   = (bus_req.wr && bus_req.sel == qslr_pkg::REG_TX_CS)
                      ? chan_hit : 4'h0;
    assign wr_tbuf  = (bus_req.wr && bus_req.sel == qslr_pkg::REG_TX_BUF)
                      ? chan_hit : 4'h0;
    assign rd_rx_data_buffer  = (bus_req.rd && bus_req.sel == qslr_pkg::REG_RX_BUF)
                      ? chan_hit : 4'h0;

    // done clears on buffer read, advance write, or init
    assign clr_done = rd_rx_data_buffer
                    | (wr_rcs & {4{bus_req.wdata[qslr_pkg::ADV_BIT]}});
    assign rx_set   = {rx_evt[3].done, rx_evt[2].done,
                       rx_evt[1].done, rx_evt[0].done};

    // arrival sets done and wins over any clear, init too
    assign rx_done_d = rx_set | (bus_init ? {4{qslr_pkg::RST_RX_DONE}}
                                          : (rx_done_q & ~clr_done));
    assign rx_ie_d   = bus_init ? {4{qslr_pkg::RST_IE}}
                     : ((rx_ie_q & ~wr_rcs)
                       | (wr_rcs & {4{bus_req.wdata[qslr_pkg::IE_BIT]}}));
    // ready falls on a buffer write, rises when the serialiser takes it
    assign tx_rdy_d  = bus_init ? {4{qslr_pkg::RST_TX_RDY}}
                     : (tx_taken | (tx_rdy_q & ~wr_tbuf));
    assign tx_ie_d   = bus_init ? {4{qslr_pkg::RST_IE}}
                     : ((tx_ie_q & ~wr_tcs)
                       | (wr_tcs & {4{bus_req.wdata[qslr_pkg::IE_BIT]}}));
    assign tx_brk_d  = bus_init ? 4'h0
                     : ((tx_brk_q & ~wr_tcs)
                       | (wr_tcs & {4{bus_req.wdata[qslr_pkg::BRK_BIT]}}));

    // control flags
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_done_q <= {4{qslr_pkg::RST_RX_DONE}};
            rx_ie_q   <= {4{qslr_pkg::RST_IE}};
            tx_rdy_q  <= {4{qslr_pkg::RST_TX_RDY}};
            tx_ie_q   <= {4{qslr_pkg::RST_IE}};
            tx_brk_q  <= 4'h0;
        end else begin
            rx_done_q <= rx_done_d;
            rx_ie_q   <= rx_ie_d;
            tx_rdy_q  <= tx_rdy_d;
            tx_ie_q   <= tx_ie_d;
            tx_brk_q  <= tx_brk_d;
        end
    end

    // character and error capture, per channel
    for (genvar c = 0; c < qslr_pkg::NUM_CH; c++) begin : g_rx
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                rx_data_q[c] <= 8'h00;
                ovr_q[c]     <= 1'b0;
                frm_q[c]     <= 1'b0;
                par_q[c]     <= 1'b0;
            end else if (rx_evt[c].done) begin
                rx_data_q[c] <= {rx_evt[c].data[7] & ~cfg_seven_bit[c],
                                 rx_evt[c].data[6:0]};
                // the serialiser's holding stage gives one character time
                ovr_q[c]     <= rx_done_q[c] & ~clr_done[c];
                frm_q[c]     <= rx_evt[c].frm_err;
                par_q[c]     <= rx_evt[c].par_err & cfg_parity_en[c];
            end else if (bus_init) begin
                ovr_q[c]     <= 1'b0;
                frm_q[c]     <= 1'b0;
            end
        end
    end

    // read data selection, unused bits zero
    always_comb begin
        rd_mux = 16'h0000;
        case (bus_req.sel)
            qslr_pkg::REG_RX_CS: begin
                rd_mux[qslr_pkg::DONE_BIT] = rx_done_q[bus_req.chan];
                rd_mux[qslr_pkg::IE_BIT]   = rx_ie_q[bus_req.chan];
            end
            qslr_pkg::REG_RX_BUF: begin
                rd_mux[7:0]               = rx_data_q[bus_req.chan];
                rd_mux[qslr_pkg::OVR_BIT] = ovr_q[bus_req.chan];
                rd_mux[qslr_pkg::FRM_BIT] = frm_q[bus_req.chan];
                rd_mux[qslr_pkg::PAR_BIT] = par_q[bus_req.chan];
                rd_mux[qslr_pkg::ERR_BIT] = ovr_q[bus_req.chan]
                                          | frm_q[bus_req.chan]
                                          | par_q[bus_req.chan];
            end
            qslr_pkg::REG_TX_CS: begin
                rd_mux[qslr_pkg::DONE_BIT] = tx_rdy_q[bus_req.chan];
                rd_mux[qslr_pkg::IE_BIT]   = tx_ie_q[bus_req.chan];
                rd_mux[qslr_pkg::BRK_BIT]  = tx_brk_q[bus_req.chan];
            end
            default: begin
                rd_mux = 16'h0000;
            end
        endcase
    end

    // registered read answer, transmit load and advance pulses
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q   <= 16'h0000;
            rvalid_q  <= 1'b0;
            tx_data_q <= 8'h00;
            tx_load_q <= 4'h0;
            adv_q     <= 4'h0;
        end else begin
            rvalid_q  <= bus_req.rd;
            if (bus_req.rd) begin
                rdata_q <= rd_mux;
            end
            if (bus_req.wr && bus_req.sel == qslr_pkg::REG_TX_BUF) begin
                tx_data_q <= bus_req.wdata[7:0];
            end
            tx_load_q <= wr_tbuf;
            adv_q     <= wr_rcs & {4{bus_req.wdata[qslr_pkg::ADV_BIT]}};
        end
    end

    // request vector: receivers then transmitters
    assign req_vec    = {tx_ie_q & tx_rdy_q, rx_ie_q & rx_done_q};
    assign any_req    = |req_vec;
    assign win_idx    = prio_pick(req_vec);
    assign grant_edge = ack_in && !ack_in_q;

    // vector answer on acknowledge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_in_q    <= 1'b0;
            vec_q       <= qslr_pkg::RST_VECTOR;
            vec_valid_q <= 1'b0;
        end else begin
            ack_in_q    <= ack_in;
            vec_valid_q <= grant_edge && any_req;
            if (grant_edge && any_req) begin
                vec_q <= BASE_VECTOR + 8'(win_idx) * qslr_pkg::VEC_STEP;
            end
        end
    end

    // grant is passed down the chain only when nothing here pends
    assign ack_out     = ack_in && !any_req;
    assign irq_req     = any_req;
    assign bus_rdata   = rdata_q;
    assign bus_rvalid  = rvalid_q;
    assign vec_data    = vec_q;
    assign vec_valid   = vec_valid_q;
    assign tx_load     = tx_load_q;
    assign tx_data     = tx_data_q;
    assign rdr_advance = adv_q;
    assign tx_break    = tx_brk_q;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_char_in(int c);
        rx_evt[c].done;
    endsequence
    sequence s_done_seen(int c);
        ##1 rx_done_q[c];
    endsequence

    a_done_sets: assert property (s_char_in(0) |-> s_done_seen(0))
        else $error("done did not set after a character");
    a_done_clear: assert property (rd_rx_data_buffer[1] && !rx_set[1]
        && !bus_init |=> !rx_done_q[1])
        else $error("buffer read left done set");
    a_req_level: assert property (req_vec == 8'h02 && rd_rx_data_buffer[1]
        && !(|rx_set) && !(|tx_taken) && !bus_req.wr && !bus_init
        |=> !irq_req)
        else $error("request stayed after its flag cleared");
    a_chain_pass: assert property (ack_out |-> ack_in && !irq_req)
        else $error("grant passed while a request pends");
    a_vec_order: assert property (grant_edge && rx_ie_q[0]
        && rx_done_q[0] |=> vec_valid && vec_data == BASE_VECTOR)
        else $error("receiver zero did not win");
    a_vec_tx3: assert property (grant_edge && req_vec == 8'h80
        |=> vec_data == BASE_VECTOR + 8'h1C)
        else $error("wrong vector for transmitter three");
    a_overrun_set: assert property (rx_evt[2].done && rx_done_q[2]
        && !clr_done[2] |=> ovr_q[2])
        else $error("overrun missed");
    a_init_ready: assert property (bus_init |=> tx_rdy_q == 4'hF
        && tx_ie_q == 4'h0 && rx_ie_q == 4'h0 && tx_brk_q == 4'h0)
        else $error("init did not set ready and clear enables");
    a_err_or: assert property (bus_rvalid
        && $past(bus_req.sel) == qslr_pkg::REG_RX_BUF
        |-> bus_rdata[15] == |bus_rdata[14:12]
        && bus_rdata[11:8] == 4'h0)
        else $error("error summary or unused bits wrong");
    a_parity_off: assert property (!cfg_parity_en[3]
        && rx_evt[3].done |=> !par_q[3])
        else $error("parity flagged without parity");
    a_seven_bit: assert property (cfg_seven_bit[3]
        && rx_evt[3].done |=> !rx_data_q[3][7])
        else $error("bit seven not cleared in seven bit mode");
    a_tx_load: assert property (wr_tbuf[2] |=> tx_load[2]
        && !tx_rdy_q[2] || $past(tx_taken[2]) || $past(bus_init))
        else $error("transmit write not passed on");
endmodule : qslr_core
`default_nettype wire

/* File: test/qslr_ser_model.sv */
`timescale 1ns/1ps
`default_nettype none
// serialiser stand-in: empties a loaded transmit buffer after a delay
module qslr_ser_model (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       slow,
    input  wire logic [3:0] tx_load,
    input  wire logic [7:0] tx_data,
    output logic      [3:0] tx_taken
);
    logic [3:0] pend_q;
    logic [3:0] cnt_q;
    logic [7:0] char_q;

    // one character in flight; prompt or slow line, then buffer empties
    always_ff @(posedge clk) begin
        tx_taken <= 4'h0;
        if (sys_rst) begin
            pend_q <= 4'h0;
            cnt_q  <= 4'h0;
            char_q <= 8'h00;
        end else if (tx_load != 4'h0) begin
            pend_q <= tx_load;
            char_q <= tx_data;
            cnt_q  <= slow ? 4'h8 : 4'h2;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
                tx_taken <= pend_q;
            end
        end
    end
endmodule : qslr_ser_model
`default_nettype wire

/* File: test/quad_serial_line_regs_irq_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module quad_serial_line_regs_irq_tb_top;
    localparam logic [7:0] BASE = 8'h40;
    logic                     clk = 1'b0;
    logic                     sys_rst = 1'b1;
    logic                     bus_init = 1'b0;
    qslr_pkg::qslr_bus_t      bus_req = '0;
    qslr_pkg::qslr_rx_t [3:0] rx_evt = '0;
    logic [3:0]               cfg_seven_bit = 4'h0;
    logic [3:0]               cfg_parity_en = 4'hF;
    logic                     ack_in = 1'b0;
    logic                     slow = 1'b0;
    logic [15:0]              bus_rdata;
    logic                     bus_rvalid;
    logic                     irq_req;
    logic                     ack_out;
    logic [7:0]               vec_data;
    logic                     vec_valid;
    logic [3:0]               rdr_advance;
    logic [3:0]               tx_load;
    logic [7:0]               tx_data;
    logic [3:0]               tx_taken;
    logic [3:0]               tx_break;
    int                       errors = 0;
    int                       n_compared = 0;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    qslr_core #(.BASE_VECTOR(BASE)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .bus_init(bus_init),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
        .irq_req(irq_req), .ack_in(ack_in), .ack_out(ack_out),
        .vec_data(vec_data), .vec_valid(vec_valid), .rx_evt(rx_evt),
        .cfg_seven_bit(cfg_seven_bit), .cfg_parity_en(cfg_parity_en),
        .rdr_advance(rdr_advance), .tx_load(tx_load), .tx_data(tx_data),
        .tx_taken(tx_taken), .tx_break(tx_break));

    qslr_ser_model u_ser (
        .clk(clk), .sys_rst(sys_rst), .slow(slow), .tx_load(tx_load),
        .tx_data(tx_data), .tx_taken(tx_taken));

    // compares one value and counts it
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // register read, answer checked the cycle after the request
    task automatic rd(input logic [1:0] c, input logic [1:0] s,
                      input logic [15:0] exp);
        @(posedge clk) bus_req <= {1'b1, 1'b0, c, s, 16'h0000};
        @(posedge clk) bus_req.rd <= 1'b0;
        #1;
        chk({15'h0000, bus_rvalid}, 16'h0001);
        chk(bus_rdata, exp);
    endtask : rd

    // register write; returns once the write has taken effect
    task automatic wr(input logic [1:0] c, input logic [1:0] s,
                      input logic [15:0] d);
        @(posedge clk) bus_req <= {1'b0, 1'b1, c, s, d};
        @(posedge clk) bus_req.wr <= 1'b0;
        #1;
    endtask : wr

    // one completed character from a receiver
    task automatic rx(input logic [1:0] c, input logic [7:0] d,
                      input logic f, input logic p);
        @(posedge clk) rx_evt[c] <= {1'b1, d, f, p};
        @(posedge clk) rx_evt[c].done <= 1'b0;
        #1;
    endtask : rx

    // grant with requests pending: grant kept, vector returned
    task automatic ack(input logic [7:0] exp);
        @(posedge clk) ack_in <= 1'b1;
        #1;
        chk({15'h0000, ack_out}, 16'h0000);
        @(posedge clk) ack_in <= 1'b0;
        #1;
        chk({15'h0000, vec_valid}, 16'h0001);
        chk({8'h00, vec_data}, {8'h00, exp});
    endtask : ack

    // bus initialise for one cycle
    task automatic init_pulse;
        @(posedge clk) bus_init <= 1'b1;
        @(posedge clk) bus_init <= 1'b0;
        #1;
    endtask : init_pulse

    // values straight after reset
    task automatic t_reset;
        rd(2'h0, qslr_pkg::REG_RX_CS, 16'h0000);
        rd(2'h0, qslr_pkg::REG_TX_CS, 16'h0080);
        wr(2'h0, qslr_pkg::REG_RX_BUF, 16'hFFFF);
        rd(2'h0, qslr_pkg::REG_RX_BUF, 16'h0000);
        chk({15'h0000, irq_req}, 16'h0000);
    endtask : t_reset

    // enabled receiver, character with parity error, read clears done
    task automatic t_rx;
        wr(2'h1, qslr_pkg::REG_RX_CS, 16'hFFFE);
        rd(2'h1, qslr_pkg::REG_RX_CS, 16'h0040);
        rx(2'h1, 8'hA5, 1'b0, 1'b1);
        chk({15'h0000, irq_req}, 16'h0001);
        rd(2'h1, qslr_pkg::REG_RX_CS, 16'h00C0);
        rd(2'h1, qslr_pkg::REG_RX_BUF, 16'h90A5);
        chk({15'h0000, irq_req}, 16'h0000);
        rd(2'h1, qslr_pkg::REG_RX_CS, 16'h0040);
    endtask : t_rx

    // second character on a set done, then initialise
    task automatic t_overrun;
        rx(2'h2, 8'h11, 1'b1, 1'b0);
        rx(2'h2, 8'h22, 1'b0, 1'b0);
        rd(2'h2, qslr_pkg::REG_RX_BUF, 16'hC022);
        rx(2'h2, 8'h33, 1'b1, 1'b0);
        init_pulse();
        rd(2'h2, qslr_pkg::REG_RX_CS, 16'h0000);
        rd(2'h2, qslr_pkg::REG_RX_BUF, 16'h0033);
        rd(2'h1, qslr_pkg::REG_RX_CS, 16'h0000);
    endtask : t_overrun

    // seven-bit channel without parity
    task automatic t_seven;
        @(posedge clk) cfg_seven_bit <= 4'h8;
        cfg_parity_en <= 4'h7;
        rx(2'h3, 8'hFF, 1'b1, 1'b1);
        rd(2'h3, qslr_pkg::REG_RX_BUF, 16'hA07F);
    endtask : t_seven

    // reader advance pulses and clears done
    task automatic t_adv;
        rx(2'h0, 8'h55, 1'b0, 1'b0);
        wr(2'h0, qslr_pkg::REG_RX_CS, 16'h0001);
        chk({12'h000, rdr_advance}, 16'h0001);
        rd(2'h0, qslr_pkg::REG_RX_CS, 16'h0000);
    endtask : t_adv

    // ranking of several pending requests, then an idle grant
    task automatic t_prio;
        wr(2'h1, qslr_pkg::REG_RX_CS, 16'h0040);
        wr(2'h2, qslr_pkg::REG_RX_CS, 16'h0040);
        rx(2'h2, 8'h02, 1'b0, 1'b0);
        rx(2'h1, 8'h01, 1'b0, 1'b0);
        wr(2'h0, qslr_pkg::REG_TX_CS, 16'h0040);
        ack(BASE + 8'h04);
        rd(2'h1, qslr_pkg::REG_RX_BUF, 16'h0001);
        ack(BASE + 8'h08);
        rd(2'h2, qslr_pkg::REG_RX_BUF, 16'h0002);
        ack(BASE + 8'h10);
        wr(2'h0, qslr_pkg::REG_TX_CS, 16'h0000);
        @(posedge clk) ack_in <= 1'b1;
        #1;
        chk({15'h0000, ack_out}, 16'h0001);
        @(posedge clk) ack_in <= 1'b0;
        #1;
        chk({15'h0000, vec_valid}, 16'h0000);
    endtask : t_prio

    // transmit load, slow serialiser, break and initialise
    task automatic t_tx;
        int n;
        n = 0;
        @(posedge clk) slow <= 1'b1;
        wr(2'h2, qslr_pkg::REG_TX_BUF, 16'hAB3C);
        chk({4'h0, tx_load, tx_data}, 16'h043C);
        rd(2'h2, qslr_pkg::REG_TX_CS, 16'h0000);
        rd(2'h2, qslr_pkg::REG_TX_BUF, 16'h0000);
        while (tx_taken[2] !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        rd(2'h2, qslr_pkg::REG_TX_CS, 16'h0080);
        wr(2'h2, qslr_pkg::REG_TX_CS, 16'hFFFF);
        chk({12'h000, tx_break}, 16'h0004);
        rd(2'h2, qslr_pkg::REG_TX_CS, 16'h00C1);
        ack(BASE + 8'h18);
        init_pulse();
        chk({12'h000, tx_break}, 16'h0000);
        rd(2'h2, qslr_pkg::REG_TX_CS, 16'h0080);
    endtask : t_tx

    // lone transmitter three, then receiver zero outranks it
    task automatic t_vec;
        wr(2'h3, qslr_pkg::REG_TX_CS, 16'h0040);
        ack(BASE + 8'h1C);
        wr(2'h0, qslr_pkg::REG_RX_CS, 16'h0040);
        rx(2'h0, 8'hC3, 1'b0, 1'b0);
        ack(BASE);
        rd(2'h0, qslr_pkg::REG_RX_BUF, 16'h00C3);
        init_pulse();
        chk({15'h0000, irq_req}, 16'h0000);
    endtask : t_vec

    // verdict and end of run
    task automatic tally_and_finish;
        if (errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_rx();
        t_overrun();
        t_seven();
        t_adv();
        t_prio();
        t_tx();
        t_vec();
        tally_and_finish();
    end

    // watchdog well past the expected hundred or so cycles
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
endmodule : quad_serial_line_regs_irq_tb_top
`default_nettype wire
